// ---- eips_pkg.sv ----
// package: constants for the external interrupt pin switch flag block
//------------------------------------------------------------
// What this block and its software do
// RULE1: irq flag sets when function bit goes 0->1, pin low, falling edge select.
// RULE2: irq flag sets when function bit goes 1->0, pin low, rising edge select.
// RULE3: wake flag sets when wake function bit goes 0->1 while pin low.
// RULE4: flag clear issued right after a pin-function access is ignored.
// RULE5: software masks, writes function bit, waits one instruction, then clears.
// RULE6: software clears flag after switching, or holds pin high during switch.
// RULE7: edge detector sees constant high while pin not in interrupt function.
// RULE8: wake flag sets on falling edge while pin assigned to wake use.
// RULE9: flags clear only by writing zero; one writes and acceptance do nothing.
// RULE10: each irq pin detects rising or falling edge per its edge select bit.
//------------------------------------------------------------
`default_nettype none
package eips_pkg;
   localparam int EIPS_IRQ_N = 5;
   localparam int EIPS_WAKE_N = 8;
   localparam int EIPS_SYNC_STAGES = 3;
   // clear blocked for this many instruction slots after a function access
   localparam int EIPS_CLR_HOLDOFF = 1;
   localparam logic [4:0] EIPS_IRQ_FLAG_RST = 5'h0_0;
   localparam logic [7:0] EIPS_WAKE_FLAG_RST = 8'h0_0;
   localparam logic [4:0] EIPS_IRQ_FUNC_RST = 5'h0_0;
   localparam logic [7:0] EIPS_WAKE_FUNC_RST = 8'h0_0;
   localparam logic [4:0] EIPS_EDGE_RST = 5'h0_0;
endpackage
`default_nettype wire

// ---- eips_edge.sv ----
// module: pin synchroniser, function gating and edge detector for one pin
`timescale 1ns/1ps
`default_nettype none
module eips_edge
   import eips_pkg::*;
(
   // clock and reset
   input wire logic i_sys_clk,
   input wire logic i_reset_n,
   // pin and control
   input wire logic i_pin,
   input wire logic i_func,
   input wire logic i_rise_sel,
   // detected edge
   output logic o_edge
);
   //------------------------------------------------------------
   // synchroniser
   //------------------------------------------------------------
   // three stages; a change counts once stages two and three agree
   logic s1_q, s2_q, s3_q, seen_q, gated_q;
   logic gated_d;
   always_ff @(posedge i_sys_clk) begin
      if (!i_reset_n) begin
         s1_q <= 1'b1;
         s2_q <= 1'b1;
         s3_q <= 1'b1;
         seen_q <= 1'b1;
         gated_q <= 1'b1;
      end else begin
         s1_q <= i_pin;
         s2_q <= s1_q;
         s3_q <= s2_q;
         if (s2_q == s3_q) begin
            seen_q <= s3_q;
         end
         gated_q <= gated_d;
      end
   end
   // RULE7: detector forced high
   // unassigned pin looks high, so switching the function makes the edge
   assign gated_d = i_func ? seen_q : 1'b1;
   // RULE10: edge per select
   wire fall_w = gated_q & ~gated_d;
   wire rise_w = ~gated_q & gated_d;
   assign o_edge = i_rise_sel ? rise_w : fall_w;
endmodule
`default_nettype wire

// ---- eips_top.sv ----
// module: external interrupt and wake request flags with pin switch effects
`timescale 1ns/1ps
`default_nettype none
module eips_top
   import eips_pkg::*;
(
   // clock and reset
   input wire logic i_sys_clk,
   input wire logic i_reset_n,
   // external pins, active low requests
   input wire logic [EIPS_IRQ_N-1:0] i_irq_pin_n,
   input wire logic [EIPS_WAKE_N-1:0] i_wake_pin_n,
   // cpu write strobes and data
   input wire logic i_irq_func_we,
   input wire logic [EIPS_IRQ_N-1:0] i_irq_func_wdata,
   input wire logic i_wake_func_we,
   input wire logic [EIPS_WAKE_N-1:0] i_wake_func_wdata,
   input wire logic i_edge_we,
   input wire logic [EIPS_IRQ_N-1:0] i_edge_wdata,
   input wire logic i_irq_flag_we,
   input wire logic [EIPS_IRQ_N-1:0] i_irq_flag_wdata,
   input wire logic i_wake_flag_we,
   input wire logic [EIPS_WAKE_N-1:0] i_wake_flag_wdata,
   // one pulse per retired instruction
   input wire logic i_instr_done,
   // register contents
   output logic [EIPS_IRQ_N-1:0] o_irq_func,
   output logic [EIPS_WAKE_N-1:0] o_wake_func,
   output logic [EIPS_IRQ_N-1:0] o_edge_sel,
   output logic [EIPS_IRQ_N-1:0] o_irq_flag,
   output logic [EIPS_WAKE_N-1:0] o_wake_flag
);
   //------------------------------------------------------------
   // control registers
   //------------------------------------------------------------
   logic [EIPS_IRQ_N-1:0] irq_func_q, edge_q, irq_flag_q, irq_flag_d, irq_edge;
   logic [EIPS_WAKE_N-1:0] wake_func_q, wake_flag_q, wake_flag_d, wake_edge;
   logic holdoff_q;
   always_ff @(posedge i_sys_clk) begin
      if (!i_reset_n) begin
         irq_func_q <= EIPS_IRQ_FUNC_RST;
         wake_func_q <= EIPS_WAKE_FUNC_RST;
         edge_q <= EIPS_EDGE_RST;
      end else begin
         if (i_irq_func_we) irq_func_q <= i_irq_func_wdata;
         if (i_wake_func_we) wake_func_q <= i_wake_func_wdata;
         if (i_edge_we) edge_q <= i_edge_wdata;
      end
   end
   //------------------------------------------------------------
   // clear holdoff
   //------------------------------------------------------------
   // RULE4: clear blocked after access
   // the next instruction after a function access cannot clear; the
   // holdoff lasts until one more instruction retires (RULE5 relies on it)
   wire func_acc_w = i_irq_func_we | i_wake_func_we;
   always_ff @(posedge i_sys_clk) begin
      if (!i_reset_n) begin
         holdoff_q <= 1'b0;
      end else if (func_acc_w) begin
         holdoff_q <= 1'b1;
      end else if (i_instr_done) begin
         holdoff_q <= 1'b0;
      end
   end
   wire clr_ok_w = ~holdoff_q & ~func_acc_w;
   //------------------------------------------------------------
   // edge detectors
   //------------------------------------------------------------
   // RULE1: falling select on enable
   // RULE2: rising select on disable
   // low pin: enabling gives 1->0, disabling gives 0->1 at the detector
   genvar g;
   generate
      for (g = 0; g < EIPS_IRQ_N; g++) begin : g_irq
         eips_edge u_edge (
            .i_sys_clk(i_sys_clk),
            .i_reset_n(i_reset_n),
            .i_pin(i_irq_pin_n[g]),
            .i_func(irq_func_q[g]),
            .i_rise_sel(edge_q[g]),
            .o_edge(irq_edge[g])
         );
      end
      // RULE3: wake enable while low
      // RULE8: wake falling edge
      for (g = 0; g < EIPS_WAKE_N; g++) begin : g_wake
         eips_edge u_edge (
            .i_sys_clk(i_sys_clk),
            .i_reset_n(i_reset_n),
            .i_pin(i_wake_pin_n[g]),
            .i_func(wake_func_q[g]),
            .i_rise_sel(1'b0),
            .o_edge(wake_edge[g])
         );
      end
   endgenerate
   //------------------------------------------------------------
   // request flags
   //------------------------------------------------------------
   // RULE9: clear by zero only
   // set wins over a clear landing in the same cycle
   wire [EIPS_IRQ_N-1:0] irq_clr_w = (i_irq_flag_we & clr_ok_w) ?
      ~i_irq_flag_wdata : '0;
   wire [EIPS_WAKE_N-1:0] wake_clr_w = (i_wake_flag_we & clr_ok_w) ?
      ~i_wake_flag_wdata : '0;
   assign irq_flag_d = (irq_flag_q & ~irq_clr_w) | irq_edge;
   assign wake_flag_d = (wake_flag_q & ~wake_clr_w) | wake_edge;
   always_ff @(posedge i_sys_clk) begin
      if (!i_reset_n) begin
         irq_flag_q <= EIPS_IRQ_FLAG_RST;
         wake_flag_q <= EIPS_WAKE_FLAG_RST;
      end else begin
         irq_flag_q <= irq_flag_d;
         wake_flag_q <= wake_flag_d;
      end
   end
   assign o_irq_func = irq_func_q;
   assign o_wake_func = wake_func_q;
   assign o_edge_sel = edge_q;
   assign o_irq_flag = irq_flag_q;
   assign o_wake_flag = wake_flag_q;
   //------------------------------------------------------------
   // assertions
   //------------------------------------------------------------
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (!i_reset_n);
   a_irq_edge_sets: assert property (|irq_edge |=> |irq_flag_q) // RULE10
      else $error("irq edge did not set flag");
   a_wake_edge_sets: assert property (|wake_edge |=> |wake_flag_q) // RULE8
      else $error("wake edge did not set flag");
   a_clear_holdoff: assert property (func_acc_w ##1 (i_irq_flag_we && !i_instr_done
      && irq_edge == '0) |=> irq_flag_q == $past(irq_flag_q)) // RULE4
      else $error("clear took effect during holdoff");
   a_flag_no_self_clr: assert property (!i_irq_flag_we && !i_wake_flag_we |=>
      (irq_flag_q & $past(irq_flag_q)) == $past(irq_flag_q)) // RULE9
      else $error("flag dropped without a zero write");
   a_wake_stable_off: assert property (wake_func_q == '0 && $past(wake_func_q) == '0
      |-> wake_edge == '0) // RULE3
      else $error("wake edge while pin unassigned");
   // pin held low long enough for the synchroniser to have settled low
   a_irq_enable_low: assert property ((!i_irq_pin_n[4]) [*8] ##0
      (!edge_q[4] && $rose(irq_func_q[4])) |-> ##[0:2] irq_flag_q[4]) // RULE1
      else $error("enable on low pin did not set flag");
   a_irq_disable_low: assert property ((!i_irq_pin_n[4]) [*8] ##0
      (edge_q[4] && $fell(irq_func_q[4])) |-> ##[0:2] irq_flag_q[4]) // RULE2
      else $error("disable on low pin did not set flag");
   a_wake_enable_low: assert property ((!i_wake_pin_n[7]) [*8] ##0
      $rose(wake_func_q[7]) |-> ##[0:2] wake_flag_q[7]) // RULE3
      else $error("wake enable on low pin did not set flag");
   // every detected irq edge lands in its own flag, whatever clear is pending
   a_set_over_clear: assert property (|irq_edge |=>
      (irq_flag_q & $past(irq_edge)) == $past(irq_edge)) // RULE9
      else $error("clear beat a set in the same cycle");
   a_wake_holdoff: assert property (func_acc_w ##1 (i_wake_flag_we && !i_instr_done
      && wake_edge == '0) |=> wake_flag_q == $past(wake_flag_q)) // RULE4
      else $error("wake clear took effect during holdoff");
   a_gated_high: assert property (irq_func_q == '0 && $past(irq_func_q) == '0
      |-> irq_edge == '0) // RULE7
      else $error("edge seen on unassigned irq pin");
   c_irq_set: cover property ($rose(irq_flag_q[0]));
   c_wake_set: cover property ($rose(wake_flag_q[7]));
   c_clear_ok: cover property ($fell(irq_flag_q[4]));
   c_holdoff: cover property (holdoff_q && i_irq_flag_we);
endmodule
`default_nettype wire

// ---- eips_pin_model.sv ----
// pin model: drives the external request pins from bench level requests
`timescale 1ns/1ps
`default_nettype none
module eips_pin_model
   import eips_pkg::*;
(
   // clock
   input wire logic i_sys_clk,
   // requested low levels
   input wire logic [EIPS_IRQ_N-1:0] i_irq_low,
   input wire logic [EIPS_WAKE_N-1:0] i_wake_low,
   // pin levels, pulled high unless asked low
   output logic [EIPS_IRQ_N-1:0] o_irq_pin_n,
   output logic [EIPS_WAKE_N-1:0] o_wake_pin_n
);
   always_ff @(posedge i_sys_clk) begin
      o_irq_pin_n <= ~i_irq_low;
      o_wake_pin_n <= ~i_wake_low;
   end
endmodule
`default_nettype wire

// ---- tb_top.sv ----
// testbench: pin switch and edge flag scenarios for the request flag block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import eips_pkg::*;
   logic clk = 1'b0, rst_n = 1'b0, instr = 1'b0;
   logic [4:0] irq_low = 5'h0_0;
   logic [7:0] wake_low = 8'h0_0;
   logic [4:0] pin_i;
   logic [7:0] pin_w;
   logic [4:0] fw = '0, ew = '0, flw = '0, d_f = '0, d_e = '0, d_fl = '0;
   logic [4:0] o_f, o_e, o_fl;
   logic [7:0] wkw = '0, d_w = '0, o_w, o_wf;
   logic [1:0] wfl = '0;
   logic [7:0] d_wf = '0;
   int err_count = 0, n_compared = 0;
   always #5 clk = ~clk;
   eips_pin_model i_pins (.i_sys_clk(clk), .i_irq_low(irq_low), .i_wake_low(wake_low),
      .o_irq_pin_n(pin_i), .o_wake_pin_n(pin_w));
   eips_top i_dut (.i_sys_clk(clk), .i_reset_n(rst_n), .i_irq_pin_n(pin_i),
      .i_wake_pin_n(pin_w), .i_irq_func_we(fw[0]), .i_irq_func_wdata(d_f),
      .i_wake_func_we(wkw[0]), .i_wake_func_wdata(d_w), .i_edge_we(ew[0]),
      .i_edge_wdata(d_e), .i_irq_flag_we(flw[0]), .i_irq_flag_wdata(d_fl),
      .i_wake_flag_we(wfl[0]), .i_wake_flag_wdata(d_wf), .i_instr_done(instr),
      .o_irq_func(o_f), .o_wake_func(o_w), .o_edge_sel(o_e), .o_irq_flag(o_fl),
      .o_wake_flag(o_wf));
   // wait n edges, then let their updates land
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      n_compared++;
      if (seen !== exp) begin
         err_count++;
         $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
      end
   endtask
   // one-cycle write: 0 func, 1 wake func, 2 edge, 3 irq flag, 4 wake flag
   task automatic wr(input int sel, input logic [7:0] d);
      @(posedge clk);
      case (sel)
         0: begin fw <= 5'h0_1; d_f <= d[4:0]; end
         1: begin wkw <= 8'h0_1; d_w <= d; end
         2: begin ew <= 5'h0_1; d_e <= d[4:0]; end
         3: begin flw <= 5'h0_1; d_fl <= d[4:0]; end
         default: begin wfl <= 2'h1; d_wf <= d; end
      endcase
      @(posedge clk);
      {fw, wkw, ew, flw, wfl} <= '0;
   endtask
   // one instruction between switch and clear
   task automatic ins();
      @(posedge clk);
      instr <= 1'b1;
      @(posedge clk);
      instr <= 1'b0;
   endtask
   task automatic s_irq_switch();
      irq_low <= 5'h1_0;
      cyc(8);
      wr(0, 8'h10);
      cyc(2);
      chk({3'h0, o_fl}, 8'h10);
      chk({3'h0, o_f}, 8'h10);
      wr(3, 8'h00);
      cyc(1);
      chk({3'h0, o_fl}, 8'h10);
      ins();
      wr(3, 8'h1f);
      cyc(1);
      chk({3'h0, o_fl}, 8'h10);
      wr(3, 8'h00);
      cyc(1);
      chk({3'h0, o_fl}, 8'h00);
      wr(2, 8'h10);
      cyc(3);
      chk({3'h0, o_fl}, 8'h00);
      chk({3'h0, o_e}, 8'h10);
      wr(0, 8'h00);
      cyc(2);
      chk({3'h0, o_fl}, 8'h10);
      ins();
      wr(3, 8'h00);
      irq_low <= 5'h0_0;
      cyc(8);
      chk({3'h0, o_fl}, 8'h00);
   endtask
   task automatic s_irq_edges();
      wr(0, 8'h01);
      cyc(3);
      irq_low <= 5'h0_1;
      cyc(8);
      chk({3'h0, o_fl}, 8'h01);
      ins();
      wr(3, 8'h00);
      wr(2, 8'h01);
      irq_low <= 5'h0_0;
      cyc(8);
      chk({3'h0, o_fl}, 8'h01);
   endtask
   task automatic s_wake();
      wake_low <= 8'h80;
      cyc(8);
      chk(o_wf, 8'h00);
      wr(1, 8'h80);
      cyc(2);
      chk(o_wf, 8'h80);
      chk(o_w, 8'h80);
      ins();
      wr(4, 8'h00);
      wake_low <= 8'h00;
      cyc(8);
      chk(o_wf, 8'h00);
      wake_low <= 8'h80;
      cyc(8);
      chk(o_wf, 8'h80);
   endtask
   task automatic conclude();
      if (err_count == 0 && n_compared > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   // main sequence after a three-cycle reset
   initial begin
      cyc(3);
      rst_n <= 1'b1;
      s_irq_switch();
      s_irq_edges();
      s_wake();
      conclude();
   end
   // watchdog well past the hundred or so cycles the scenarios need
   initial begin
      #50000;
      err_count++;
      conclude();
   end
endmodule
`default_nettype wire
